// >>> fsg_pkg.sv
package fsg_pkg;

  localparam int unsigned ADDR_W = 24;
  localparam int unsigned SECT_W = 7;
  localparam int unsigned NUM_SECT = 128;
  localparam int unsigned SECT_LSB = 16;
  localparam int unsigned CNT_W = 16;

  // whole-byte check looks at the low three bits of the clock count
  localparam int unsigned BYTE_LSB_W = 3;

  // lock data field positions on lock_wdata_i
  localparam int unsigned LOCK_WR_POS = 0;
  localparam int unsigned LOCK_DN_POS = 1;

  localparam logic WEL_RST = 1'b0;
  localparam logic LOCK_RST = 1'b0;

  // supply-good settle time after power-on or a brown-out
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned POR_TIME_US = 100;
  localparam int unsigned POR_CYCLES = POR_TIME_US * CLK_MHZ;
  localparam int unsigned POR_W = 16;

  typedef enum logic [2:0] {
    FSG_CMD_NONE = 3'b000,
    FSG_CMD_WREN = 3'b001,
    FSG_CMD_WRDI = 3'b010,
    FSG_CMD_PROGRAM = 3'b011,
    FSG_CMD_ERASE = 3'b100,
    FSG_CMD_REG_WRITE = 3'b101,
    FSG_CMD_LOCK_WRITE = 3'b110
  } fsg_cmd_t;

  typedef enum logic [1:0] {
    FSG_PWR_WAIT = 2'b00,
    FSG_PWR_RUN = 2'b01
  } fsg_pwr_t;

endpackage : fsg_pkg

// >>> fsg_write_guard.sv
// Summary of operation
// - modifying commands need a whole-byte frame clock count.
// - arming command sets write enable latch; modifying commands need it.
// - program and erase refused in a sector whose write lock bit is one.
// - lock-down one freezes the sector write lock until reset.
// - sector lock bits change only when the lock update command executes.
// - lock update command ignored while the sector is locked down.
// - top select, msb zero: code n protects the top 2^(n-1) sectors.
// - bottom select, msb zero: code n protects the lowest 2^(n-1) sectors.
// - protect size msb set protects every sector.
// - reset and a settle timer inhibit data changes while supply is bad.
// - sector index is address bits 22:16 of the 24-bit address.
// - protect pin low blocks register writes to freeze the region.
`timescale 1ns/1ps
module fsg_write_guard #(
  parameter int unsigned POR_CYCLES = fsg_pkg::POR_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic cmd_done_i,
  input wire logic [2:0] cmd_i,
  input wire logic [fsg_pkg::ADDR_W-1:0] addr_i,
  input wire logic [fsg_pkg::CNT_W-1:0] clk_count_i,
  input wire logic [1:0] lock_wdata_i,
  input wire logic top_bottom_i,
  input wire logic protect_size_msb_i,
  input wire logic protect_size_bit2_i,
  input wire logic protect_size_bit1_i,
  input wire logic protect_size_bit0_i,
  input wire logic write_protect_b_i,
  input wire logic supply_ok_i,
  input wire logic reject_clear_i,
  output logic grant_o,
  output logic refuse_o,
  output logic reject_flag_o,
  output logic wel_o,
  output logic inhibit_o,
  output logic [1:0] lock_status_o
);

  logic [2:0] wp_sync_r;
  logic [2:0] sup_sync_r;
  logic wp_b_r;
  logic sup_ok_r;
  fsg_pkg::fsg_pwr_t pwr_r;
  logic [fsg_pkg::POR_W-1:0] por_cnt_r;
  logic [fsg_pkg::NUM_SECT-1:0] lock_wr_r;
  logic [fsg_pkg::NUM_SECT-1:0] lock_dn_r;
  logic [fsg_pkg::SECT_W-1:0] sect;
  logic whole;
  logic inhibit;
  logic sect_ok;
  logic modify;
  logic ok;

  // true when the block-protect code covers the given sector
  function automatic logic bp_covers(
    input logic tb,
    input logic [3:0] bp,
    input logic [fsg_pkg::SECT_W-1:0] s
  );
    logic [fsg_pkg::SECT_W:0] size;
    logic hit;
    size = '0;
    hit = 1'b0;
    if (bp[3]) begin
      hit = 1'b1;
    end else if (bp[2:0] != 3'h0) begin
      size = (fsg_pkg::SECT_W+1)'(1) << (bp[2:0] - 3'h1);
      if (tb) begin
        hit = {1'b0, s} < size;
      end else begin
        hit = {1'b0, s} >= (8'h80 - size);
      end
    end
    return hit;
  endfunction : bp_covers

  // sector index from the address; bit 23 lies beyond the array
  assign sect = addr_i[fsg_pkg::SECT_LSB +: fsg_pkg::SECT_W];
  assign whole = clk_count_i[fsg_pkg::BYTE_LSB_W-1:0] == 3'h0;
  assign inhibit = (pwr_r != fsg_pkg::FSG_PWR_RUN) || !sup_ok_r;
  assign modify = (cmd_i == fsg_pkg::FSG_CMD_PROGRAM) ||
    (cmd_i == fsg_pkg::FSG_CMD_ERASE) ||
    (cmd_i == fsg_pkg::FSG_CMD_REG_WRITE) ||
    (cmd_i == fsg_pkg::FSG_CMD_LOCK_WRITE);

  always_comb begin
    sect_ok = 1'b0;
    case (cmd_i)
      fsg_pkg::FSG_CMD_PROGRAM,
      fsg_pkg::FSG_CMD_ERASE: begin
        sect_ok = !lock_wr_r[sect] &&
          !bp_covers(top_bottom_i, {protect_size_msb_i,
          protect_size_bit2_i, protect_size_bit1_i,
          protect_size_bit0_i}, sect);
      end
      fsg_pkg::FSG_CMD_REG_WRITE: begin
        sect_ok = wp_b_r;
      end
      fsg_pkg::FSG_CMD_LOCK_WRITE: begin
        sect_ok = !lock_dn_r[sect];
      end
      default: begin
        sect_ok = 1'b0;
      end
    endcase
  end

  // every check must pass; decisions use state from before the edge
  assign ok = modify && whole && wel_o && !inhibit && sect_ok;

  // pin synchronisers: value moves once stages two and three agree
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wp_sync_r <= 3'h7;
      sup_sync_r <= 3'h0;
      wp_b_r <= 1'b1;
      sup_ok_r <= 1'b0;
    end else begin
      wp_sync_r <= {wp_sync_r[1:0], write_protect_b_i};
      sup_sync_r <= {sup_sync_r[1:0], supply_ok_i};
      if (wp_sync_r[1] == wp_sync_r[2]) begin
        wp_b_r <= wp_sync_r[2];
      end
      if (sup_sync_r[1] == sup_sync_r[2]) begin
        sup_ok_r <= sup_sync_r[2];
      end
    end
  end

  // power-on settle timer, restarted by any supply drop
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pwr_r <= fsg_pkg::FSG_PWR_WAIT;
      por_cnt_r <= '0;
    end else begin
      case (pwr_r)
        fsg_pkg::FSG_PWR_WAIT: begin
          if (!sup_ok_r) begin
            por_cnt_r <= '0;
          end else if (por_cnt_r == fsg_pkg::POR_W'(POR_CYCLES - 1)) begin
            pwr_r <= fsg_pkg::FSG_PWR_RUN;
          end else begin
            por_cnt_r <= por_cnt_r + 1'b1;
          end
        end
        fsg_pkg::FSG_PWR_RUN: begin
          if (!sup_ok_r) begin
            pwr_r <= fsg_pkg::FSG_PWR_WAIT;
            por_cnt_r <= '0;
          end
        end
        default: begin
          pwr_r <= fsg_pkg::FSG_PWR_WAIT;
        end
      endcase
    end
  end

  // write enable latch
  // refused commands leave the latch armed
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wel_o <= fsg_pkg::WEL_RST;
    end else if (cmd_done_i && whole) begin
      if (cmd_i == fsg_pkg::FSG_CMD_WREN && !inhibit) begin
        wel_o <= 1'b1;
      end else if (cmd_i == fsg_pkg::FSG_CMD_WRDI || ok) begin
        wel_o <= 1'b0;
      end
    end
  end

  // sector lock bits, written by the lock update command and cleared by reset
  // a locked-down sector refuses the update itself, so its bits stay fixed
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lock_wr_r <= {fsg_pkg::NUM_SECT{fsg_pkg::LOCK_RST}};
      lock_dn_r <= {fsg_pkg::NUM_SECT{fsg_pkg::LOCK_RST}};
    end else if (cmd_done_i && ok &&
        cmd_i == fsg_pkg::FSG_CMD_LOCK_WRITE) begin
      lock_wr_r[sect] <= lock_wdata_i[fsg_pkg::LOCK_WR_POS];
      lock_dn_r[sect] <= lock_wdata_i[fsg_pkg::LOCK_DN_POS];
    end
  end

  // decision outputs
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      grant_o <= 1'b0;
      refuse_o <= 1'b0;
      lock_status_o <= 2'h0;
    end else begin
      grant_o <= cmd_done_i && ok;
      refuse_o <= cmd_done_i && modify && !ok;
      if (cmd_done_i) begin
        lock_status_o <= {lock_dn_r[sect], lock_wr_r[sect]};
      end
    end
  end

  // sticky reject flag; a new reject wins over a clear
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reject_flag_o <= 1'b0;
    end else if (cmd_done_i && modify && !ok) begin
      reject_flag_o <= 1'b1;
    end else if (reject_clear_i) begin
      reject_flag_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      inhibit_o <= 1'b1;
    end else begin
      inhibit_o <= inhibit;
    end
  end

endmodule : fsg_write_guard

// >>> fsg_host_model.sv
`timescale 1ns/1ps
module fsg_host_model (
  input wire logic clk_i,
  output logic cd_o = 1'b0,
  output logic [2:0] c_o = 3'h0,
  output logic [23:0] a_o = 24'h0,
  output logic [15:0] n_o = 16'h0,
  output logic [1:0] l_o = 2'h0
);
  // one frame; address and count scrambled once the strobe drops
  task send(input logic [2:0] c, input logic [23:0] a, input logic [15:0] n,
            input logic [1:0] l);
    @(negedge clk_i);
    cd_o = 1'b1;
    c_o = c;
    a_o = a;
    n_o = n;
    l_o = l;
    @(negedge clk_i);
    cd_o = 1'b0;
    a_o = ~a;
    n_o = ~n;
  endtask : send
endmodule : fsg_host_model

// >>> fsg_write_guard_sva.sv
`timescale 1ns/1ps
module fsg_write_guard_sva (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic cmd_done_i,
  input wire logic [2:0] cmd_i,
  input wire logic [23:0] addr_i,
  input wire logic [15:0] clk_count_i,
  input wire logic top_bottom_i,
  input wire logic protect_size_msb_i,
  input wire logic protect_size_bit0_i,
  input wire logic grant_o,
  input wire logic refuse_o,
  input wire logic reject_flag_o,
  input wire logic wel_o,
  input wire logic [1:0] lock_status_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  wire logic md = cmd_done_i && cmd_i >= 3'h3 && cmd_i <= 3'h6;
  wire logic pe = cmd_done_i && (cmd_i == 3'h3 || cmd_i == 3'h4);
  wire logic lo = !protect_size_msb_i && protect_size_bit0_i;
  AST_BYTE: assert property (md && clk_count_i[2:0] != 3'h0
    |=> refuse_o)
    else $error("partial byte");
  AST_WEL: assert property (md && !wel_o |=> refuse_o)
    else $error("no latch");
  AST_GCAUSE: assert property (grant_o |-> $past(wel_o) && !wel_o)
    else $error("grant latch");
  AST_MSB: assert property (pe && protect_size_msb_i |=> refuse_o)
    else $error("msb");
  AST_TOP: assert property (pe && !top_bottom_i && lo
    && addr_i[22:16] == 7'h7f |=> refuse_o)
    else $error("top");
  AST_BOT: assert property (pe && top_bottom_i && lo
    && addr_i[22:16] == 7'h00 |=> refuse_o)
    else $error("bottom");
  AST_FLAG: assert property (refuse_o |-> reject_flag_o)
    else $error("flag");
  AST_LSTAT: assert property (!cmd_done_i |=> $stable(lock_status_o))
    else $error("lock status");
  cover property (grant_o);
  cover property (refuse_o);
  cover property ($rose(wel_o));
endmodule : fsg_write_guard_sva
bind fsg_write_guard fsg_write_guard_sva i_fsg_write_guard_sva (.*);

// >>> fsg_write_guard_test.sv
`timescale 1ns/1ps
module fsg_write_guard_test;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic tb = 1'b0;
  logic [3:0] bp = 4'h0;
  logic sup = 1'b1;
  logic clr = 1'b0;
  logic wp = 1'b1;
  logic [6:0] pr, un;
  logic cd, g, r, f, w, inh;
  logic [2:0] c;
  logic [23:0] a;
  logic [15:0] n;
  logic [1:0] l, ls;
  int fail_count = 0;
  int num_checks = 0;
  initial forever #10 clk_i = ~clk_i;
  fsg_host_model i_fsg_host_model (.clk_i(clk_i), .cd_o(cd), .c_o(c),
    .a_o(a), .n_o(n), .l_o(l));
  fsg_write_guard #(.POR_CYCLES(8)) i_fsg_write_guard (.clk_i(clk_i),
    .rst_b_i(rst_b_i), .cmd_done_i(cd), .cmd_i(c), .addr_i(a),
    .clk_count_i(n), .lock_wdata_i(l), .top_bottom_i(tb),
    .protect_size_msb_i(bp[3]), .protect_size_bit2_i(bp[2]),
    .protect_size_bit1_i(bp[1]), .protect_size_bit0_i(bp[0]),
    .write_protect_b_i(wp), .supply_ok_i(sup), .reject_clear_i(clr),
    .grant_o(g), .refuse_o(r), .reject_flag_o(f), .wel_o(w),
    .inhibit_o(inh), .lock_status_o(ls));
  task chk(input string nm, input logic [1:0] s, input logic [1:0] e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  task results;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  task tx(input logic [2:0] cc, input logic [6:0] s, input logic [1:0] ll);
    i_fsg_host_model.send(cc, {1'b0, s, 16'h1234}, 16'h20, ll);
  endtask : tx
  // arm the latch, then one modifying command
  task arm(input logic [2:0] cc, input logic [6:0] s, input logic [1:0] ll,
           input logic e);
    tx(3'h1, 7'h0, 2'h0);
    tx(cc, s, ll);
    chk("grant", g, e);
    chk("refuse", r, !e);
  endtask : arm
  task do_reset;
    int k;
    rst_b_i = 1'b0;
    repeat (12) @(negedge clk_i);
    rst_b_i = 1'b1;
    for (k = 0; k < 40 && inh !== 1'b0; k++) @(negedge clk_i);
    chk("inhibit", inh, 1'b0);
  endtask : do_reset
  initial begin
    do_reset();
    tx(3'h1, 7'h1, 2'h0);
    chk("wel", w, 1'b1);
    i_fsg_host_model.send(3'h3, 24'h010000, 16'h21, 2'h0);
    chk("odd", r, 1'b1);
    tx(3'h3, 7'h1, 2'h0);
    chk("wel_clr", w, 1'b0);
    tx(3'h4, 7'h1, 2'h0);
    chk("nowel", r, 1'b1);
    clr = 1'b1;
    @(negedge clk_i);
    clr = 1'b0;
    chk("flag", f, 1'b0);
    tx(3'h1, 7'h2, 2'h0);
    tx(3'h2, 7'h2, 2'h0);
    chk("wrdi", w, 1'b0);
    wp = 1'b0;
    repeat (5) @(negedge clk_i);
    arm(3'h5, 7'h2, 2'h0, 1'b0);
    chk("flag_set", f, 1'b1);
    wp = 1'b1;
    repeat (5) @(negedge clk_i);
    arm(3'h5, 7'h2, 2'h0, 1'b1);
    for (int t = 0; t < 2; t++) begin
      tb = t[0];
      for (int m = 1; m < 8; m++) begin
        bp = m[3:0];
        pr = t ? 7'((1 << (m - 1)) - 1) : 7'(128 - (1 << (m - 1)));
        un = t ? 7'(1 << (m - 1)) : 7'(127 - (1 << (m - 1)));
        arm(3'h3, pr, 2'h0, 1'b0);
        arm(3'h4, un, 2'h0, 1'b1);
      end
    end
    bp = 4'hf;
    arm(3'h4, 7'h40, 2'h0, 1'b0);
    bp = 4'h0;
    arm(3'h6, 7'h05, 2'h1, 1'b1);
    arm(3'h3, 7'h05, 2'h0, 1'b0);
    chk("lock", ls, 2'h1);
    arm(3'h6, 7'h05, 2'h2, 1'b1);
    arm(3'h3, 7'h05, 2'h0, 1'b1);
    arm(3'h6, 7'h05, 2'h1, 1'b0);
    chk("lock", ls, 2'h2);
    sup = 1'b0;
    repeat (6) @(negedge clk_i);
    arm(3'h3, 7'h10, 2'h0, 1'b0);
    sup = 1'b1;
    do_reset();
    arm(3'h6, 7'h05, 2'h0, 1'b1);
    results();
  end
  // hang guard
  initial begin
    #100us;
    fail_count++;
    results();
  end
endmodule : fsg_write_guard_test
